// ### include/tmr8_pkg.sv
// Package of constants and types for the eight-bit timer with one compare.
package tmr8_pkg;

  // Counter width and boundary values.
  localparam int CountWidth = 8;
  localparam logic [7:0] BottomValue = 8'h00;
  localparam logic [7:0] MaxValue = 8'hff;

  // Reset values of the stored state.
  localparam logic [7:0] CounterReset = 8'h00;
  localparam logic [7:0] CompareReset = 8'h00;
  localparam logic OutputReset = 1'b0;

  // Prescaler width and tap positions for the divided internal clock.
  localparam int PrescaleWidth = 10;
  localparam int TapDiv8 = 2;
  localparam int TapDiv64 = 5;
  localparam int TapDiv256 = 7;
  localparam int TapDiv1024 = 9;

  // Clock select encodings.
  typedef enum logic [2:0] {
    CLK_STOP = 3'h0,
    CLK_DIV1 = 3'h1,
    CLK_DIV8 = 3'h2,
    CLK_DIV64 = 3'h3,
    CLK_DIV256 = 3'h4,
    CLK_DIV1024 = 3'h5,
    CLK_EXT_FALL = 3'h6,
    CLK_EXT_RISE = 3'h7
  } tmr8_clock_select_type;

  // Waveform mode encodings.
  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'h0,
    WAVE_PHASE_PWM = 2'h1,
    WAVE_CLEAR_ON_MATCH = 2'h2,
    WAVE_FAST_PWM = 2'h3
  } tmr8_waveform_type;

  // Output action encodings.
  localparam logic [1:0] ActionNone = 2'h0;
  localparam logic [1:0] ActionToggle = 2'h1;
  localparam logic [1:0] ActionClear = 2'h2;
  localparam logic [1:0] ActionSet = 2'h3;

endpackage

// ### logic/tmr8_tick_select.sv
// Clock source selection: prescaler and external count pin edge detect.
`timescale 1ns/100ps
module tmr8_tick_select #(
  parameter int PrescaleWidth = tmr8_pkg::PrescaleWidth
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Source selection.
  input wire logic [2:0] clockSelect,
  input wire logic extCountPin,
  // Selected timer tick, a one-cycle enable.
  output logic timerTick
);

  // Free running prescaler; it runs whether or not the timer uses it.
  logic [PrescaleWidth-1:0] prescale_q;
  logic [PrescaleWidth-1:0] prescale_d;
  // Two-stage synchroniser and a third stage for edge detection.
  logic [2:0] extSync_q;
  logic [2:0] extSync_d;
  logic tick;

  // Returns one when the low bits up to a tap are all ones.
  function automatic logic tapReached(
    input logic [PrescaleWidth-1:0] value,
    input int tap
  );
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < PrescaleWidth; i++) begin
      if (i <= tap) begin
        hit = hit & value[i];
      end
    end
    return hit;
  endfunction

  // Next values of the prescaler and the pin samples.
  always_comb begin
    prescale_d = prescale_q + PrescaleWidth'(1);
    extSync_d = {extSync_q[1:0], extCountPin};
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (reset) begin
      prescale_q <= '0;
      extSync_q <= 3'h0;
    end else begin
      prescale_q <= prescale_d;
      extSync_q <= extSync_d;
    end
  end

  // Pick the source and the edge; stage 0 is read only by stage 1.
  always_comb begin
    case (tmr8_pkg::tmr8_clock_select_type'(clockSelect))
      tmr8_pkg::CLK_STOP: tick = 1'b0;
      tmr8_pkg::CLK_DIV1: tick = 1'b1;
      tmr8_pkg::CLK_DIV8: tick = tapReached(prescale_q, tmr8_pkg::TapDiv8);
      tmr8_pkg::CLK_DIV64: tick = tapReached(prescale_q, tmr8_pkg::TapDiv64);
      tmr8_pkg::CLK_DIV256: tick = tapReached(prescale_q, tmr8_pkg::TapDiv256);
      tmr8_pkg::CLK_DIV1024: begin
        tick = tapReached(prescale_q, tmr8_pkg::TapDiv1024);
      end
      tmr8_pkg::CLK_EXT_FALL: tick = extSync_q[2] & ~extSync_q[1];
      default: tick = ~extSync_q[2] & extSync_q[1];
    endcase
  end

  assign timerTick = tick;

endmodule // tmr8_tick_select

// ### logic/tmr8_wave_gen.sv
// Waveform generator: holds the compare output bit and applies actions.
`timescale 1ns/100ps
module tmr8_wave_gen (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Mode and action settings, used as written.
  input wire logic [1:0] waveformMode,
  input wire logic [1:0] outputAction,
  // Events from the counter and comparator, and the force strobe.
  input wire logic matchEvent,
  input wire logic bottomEvent,
  input wire logic forceEvent,
  // Internal compare output state.
  output logic compareOutput
);

  logic out_q;
  logic out_d;
  logic isPwm;

  // Next output state; mode changes alone never touch it.
  always_comb begin
    out_d = out_q;
    isPwm = waveformMode[0];
    if (!isPwm) begin
      // Normal and clear-on-match: set, clear or toggle on match or force.
      if (matchEvent || forceEvent) begin
        case (outputAction)
          tmr8_pkg::ActionToggle: out_d = ~out_q;
          tmr8_pkg::ActionClear: out_d = 1'b0;
          tmr8_pkg::ActionSet: out_d = 1'b1;
          default: out_d = out_q;
        endcase
      end
    end else if (outputAction[1]) begin
      // Fast PWM: non-inverted clears on match, sets at bottom; inverted swaps.
      if (waveformMode == tmr8_pkg::WAVE_FAST_PWM) begin
        if (matchEvent) begin
          out_d = outputAction[0];
        end else if (bottomEvent) begin
          out_d = ~outputAction[0];
        end
      end else if (matchEvent) begin
        // Phase correct: bottomEvent is high on the up slope here, where
        // the match gives the low action bit; the down slope its inverse.
        out_d = bottomEvent ? outputAction[0] : ~outputAction[0];
      end
    end
  end

  // Registers only; reset drives the output bit to zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      out_q <= tmr8_pkg::OutputReset;
    end else begin
      out_q <= out_d;
    end
  end

  assign compareOutput = out_q;

endmodule // tmr8_wave_gen

// ### logic/tmr8_timer.sv
// Top of the eight-bit timer/counter with a single compare unit.
`timescale 1ns/100ps
// Summary of operation
// - Counter, compare and comparator are eight bits.
// - Counter moves only on timer tick.
// - Tick from prescaler or external pin edge.
// - Counter readable and writable at any time.
// - Processor write beats clear or count.
// - Bottom zero, max all ones, top per mode.
// - Tick clears, increments or decrements; flags extremes.
// - Waveform mode sets sequence and overflow condition.
// - Equality matches; flag sets next tick.
// - Compare request needs enable and global enable.
// - Compare flag clears when interrupt executes.
// - Writing one clears compare flag.
// - Requests shown as flags, gated by masks.
// - Compare buffered only in PWM modes.
// - Buffer copies to active on the tick at max.
// - Force updates output outside PWM only, no flag, no clear.
// - Counter write blocks match next tick.
// - Output state kept across mode change.
// - Output action bits act immediately.
// - Output formed from match, max, bottom.
// - Normal counts up, wraps, overflow at zero.
// - Clear-on-match clears counter at compare.
// - Fast PWM counts bottom to max, restarts.
// - Reset clears compare output to zero.
module tmr8_timer #(
  parameter int CountWidth = tmr8_pkg::CountWidth
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Control settings from the processor.
  input wire logic [2:0] clockSelect,
  input wire logic [1:0] waveformMode,
  input wire logic [1:0] outputAction,
  input wire logic forceCompare,
  input wire logic compareIrqEnable,
  input wire logic overflowIrqEnable,
  input wire logic globalIrqEnable,
  // Counter value access.
  input wire logic counterWrite,
  input wire logic [CountWidth-1:0] counterWriteData,
  output logic [CountWidth-1:0] counterValue,
  // Compare value access.
  input wire logic compareWrite,
  input wire logic [CountWidth-1:0] compareWriteData,
  output logic [CountWidth-1:0] compareValue,
  // Flag clearing by software writes of one, and by interrupt execution.
  input wire logic clearCompareFlag,
  input wire logic clearOverflowFlag,
  input wire logic compareIrqAck,
  input wire logic overflowIrqAck,
  // External count pin.
  input wire logic extCountPin,
  // Flags, requests and compare output.
  output logic compareFlag,
  output logic overflowFlag,
  output logic compareIrq,
  output logic overflowIrq,
  output logic compareOutput
);

  typedef logic [CountWidth-1:0] tmr8_word_type;

  // Counter state and its count direction (one means down).
  tmr8_word_type count_q;
  tmr8_word_type count_d;
  logic down_q;
  logic down_d;
  // Active compare register and the buffer seen by the processor in PWM.
  tmr8_word_type active_q;
  tmr8_word_type active_d;
  tmr8_word_type buffer_q;
  tmr8_word_type buffer_d;
  // Sticky flags.
  logic cmpFlag_q;
  logic cmpFlag_d;
  logic ovfFlag_q;
  logic ovfFlag_d;
  // Blocks compare matches until the next tick after a counter write.
  // It is a register, not a pulse, because a stopped timer may sit for
  // a long time between the write and the first tick.
  logic block_q;
  logic block_d;

  // One-cycle enable from the clock selection logic.
  logic timerTick;
  // High in both PWM modes, where the compare value is buffered.
  logic isPwm;
  // Comparator output, valid in every cycle.
  logic rawMatch;
  // Match that is allowed to act, qualified by tick and block.
  logic matchTick;
  // Counter at its maximum value.
  logic atMax;
  // Counter at its bottom value.
  logic atBottom;
  // Bottom or slope indication for the waveform generator.
  logic wgBottom;
  // Match indication for the waveform generator.
  logic wgMatch;
  // Overflow event, high for the one cycle whose tick overflows.
  logic ovfEvent;
  // Highest value of the count sequence in the current mode.
  tmr8_word_type topValue;

  // Timer tick source.
  tmr8_tick_select u_tick (
    .clk(clk),
    .reset(reset),
    .clockSelect(clockSelect),
    .extCountPin(extCountPin),
    .timerTick(timerTick)
  );

  // PWM modes have the low mode bit set.
  assign isPwm = waveformMode[0];
  // Comparator runs every cycle against the active register.
  assign rawMatch = (count_q == active_q);
  assign atMax = (count_q == tmr8_pkg::MaxValue);
  assign atBottom = (count_q == tmr8_pkg::BottomValue);
  // A match takes effect on the tick that moves the counter off the
  // matching value, unless a counter write blocked it. The live
  // comparator keeps the flag one tick after the match even at the
  // full clock rate; a registered copy would lag a tick behind.
  assign matchTick = timerTick & rawMatch & ~block_q;

  // Top value: compare register in clear-on-match, else the fixed max.
  always_comb begin
    if (waveformMode == tmr8_pkg::WAVE_CLEAR_ON_MATCH) begin
      topValue = active_q;
    end else begin
      // Normal and both PWM modes run up to the fixed maximum.
      topValue = tmr8_pkg::MaxValue;
    end
  end

  // Counter sequence per mode; a processor write overrides any tick action.
  always_comb begin
    count_d = count_q;
    down_d = down_q;
    ovfEvent = 1'b0;
    if (counterWrite) begin
      count_d = counterWriteData;
    end else if (timerTick) begin
      case (tmr8_pkg::tmr8_waveform_type'(waveformMode))
        tmr8_pkg::WAVE_NORMAL: begin
          // Up only; the natural wrap from max gives the overflow.
          count_d = count_q + CountWidth'(1);
          ovfEvent = atMax;
        end
        tmr8_pkg::WAVE_CLEAR_ON_MATCH: begin
          // A top set below the current count is only met after a wrap.
          if (count_q == topValue) begin
            count_d = tmr8_pkg::BottomValue;
          end else begin
            count_d = count_q + CountWidth'(1);
          end
          ovfEvent = atMax;
        end
        tmr8_pkg::WAVE_FAST_PWM: begin
          // Single slope: the counter simply wraps from max to bottom.
          count_d = count_q + CountWidth'(1);
          ovfEvent = atMax;
        end
        default: begin
          // Dual slope: turn at max and at bottom, overflow at bottom.
          if (!down_q && atMax) begin
            // Turn at max; the next value is already one below it.
            down_d = 1'b1;
            count_d = count_q - CountWidth'(1);
          end else if (down_q && atBottom) begin
            // Turn at bottom; this is the overflow point of the mode.
            down_d = 1'b0;
            count_d = count_q + CountWidth'(1);
            ovfEvent = 1'b1;
          end else if (down_q) begin
            // Down slope.
            count_d = count_q - CountWidth'(1);
          end else begin
            // Up slope.
            count_d = count_q + CountWidth'(1);
          end
        end
      endcase
    end
    if (!isPwm) begin
      // Outside PWM the direction is always up, so a later switch into
      // phase correct PWM starts on the up slope.
      down_d = 1'b0;
    end
  end

  // Compare register update: direct outside PWM, buffered inside.
  always_comb begin
    active_d = active_q;
    buffer_d = buffer_q;
    if (compareWrite) begin
      buffer_d = compareWriteData;
      if (!isPwm) begin
        active_d = compareWriteData;
      end
    end
    if (!isPwm) begin
      // Keep the buffer equal to the active value, so that entering PWM
      // starts from the value in use.
      buffer_d = compareWrite ? compareWriteData : active_q;
    end else if (timerTick) begin
      // Fast PWM loads at max, phase correct at the turn at max.
      if (atMax) begin
        active_d = buffer_q;
      end
    end
  end

  // Block state: set by any counter write, released by the next tick.
  always_comb begin
    block_d = block_q;
    if (counterWrite) begin
      // A write in the same cycle as a tick keeps the block for the
      // following tick, since the tick itself is discarded.
      block_d = 1'b1;
    end else if (timerTick) begin
      // The tick that was blocked has now passed.
      block_d = 1'b0;
    end
  end

  // Flags: hardware set wins over any clear in the same cycle.
  always_comb begin
    cmpFlag_d = cmpFlag_q;
    ovfFlag_d = ovfFlag_q;
    if (clearCompareFlag || compareIrqAck) begin
      cmpFlag_d = 1'b0;
    end
    if (clearOverflowFlag || overflowIrqAck) begin
      ovfFlag_d = 1'b0;
    end
    // Sets come last, so an event in the same cycle beats a clear.
    if (matchTick) begin
      cmpFlag_d = 1'b1;
    end
    if (ovfEvent) begin
      ovfFlag_d = 1'b1;
    end
  end

  // Registers only. Reset is synchronous, so every stored value returns
  // to its reset value on the first clock edge with reset high.
  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= tmr8_pkg::CounterReset;
      down_q <= 1'b0;
      active_q <= tmr8_pkg::CompareReset;
      buffer_q <= tmr8_pkg::CompareReset;
      cmpFlag_q <= 1'b0;
      ovfFlag_q <= 1'b0;
      block_q <= 1'b0;
    end else begin
      count_q <= count_d;
      down_q <= down_d;
      active_q <= active_d;
      buffer_q <= buffer_d;
      cmpFlag_q <= cmpFlag_d;
      ovfFlag_q <= ovfFlag_d;
      block_q <= block_d;
    end
  end

  // Waveform events: in phase correct, bottom flag marks the up slope.
  assign wgMatch = matchTick;
  assign wgBottom = isPwm && waveformMode == tmr8_pkg::WAVE_PHASE_PWM ?
                    ~down_q : (timerTick & atMax);

  // Waveform generator holds the compare output bit.
  tmr8_wave_gen u_wave (
    .clk(clk),
    .reset(reset),
    .waveformMode(waveformMode),
    .outputAction(outputAction),
    .matchEvent(wgMatch),
    .bottomEvent(wgBottom),
    .forceEvent(forceCompare & ~isPwm),
    .compareOutput(compareOutput)
  );

  // Visible state; the processor reads the buffer when buffering is on.
  // Outside PWM the buffer is written with the active register and otherwise copies it.
  assign counterValue = count_q;
  assign compareValue = buffer_q;
  assign compareFlag = cmpFlag_q;
  assign overflowFlag = ovfFlag_q;
  // Each request is masked by its own enable and the global enable.
  assign compareIrq = cmpFlag_q & compareIrqEnable & globalIrqEnable;
  assign overflowIrq = ovfFlag_q & overflowIrqEnable & globalIrqEnable;

endmodule // tmr8_timer

// ### bench/tmr8_timer_sva.sv
// Port checker for the eight-bit timer, bound into its top module.
`timescale 1ns/100ps
module tmr8_timer_sva #(
  parameter int CountWidth = tmr8_pkg::CountWidth
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Settings and strobes.
  input wire logic [2:0] clockSelect,
  input wire logic [1:0] waveformMode,
  input wire logic [1:0] outputAction,
  input wire logic forceCompare,
  input wire logic compareIrqEnable,
  input wire logic overflowIrqEnable,
  input wire logic globalIrqEnable,
  input wire logic counterWrite,
  input wire logic [CountWidth-1:0] counterWriteData,
  input wire logic compareWrite,
  input wire logic clearCompareFlag,
  input wire logic compareIrqAck,
  // Observed state.
  input wire logic [CountWidth-1:0] counterValue,
  input wire logic [CountWidth-1:0] compareValue,
  input wire logic compareFlag,
  input wire logic overflowFlag,
  input wire logic compareIrq,
  input wire logic overflowIrq,
  input wire logic compareOutput
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Three stopped cycles, so no tick can still be in flight.
  sequence s_stopped;
    (clockSelect == 3'h0) [*3];
  endsequence
  // Full-rate running in one mode with no processor writes.
  sequence s_run(logic [1:0] m);
    (clockSelect == 3'h1 && waveformMode == m && !counterWrite &&
     !compareWrite) [*3];
  endsequence
  a_stop_holds: assert property (
    s_stopped ##0 !counterWrite |=> $stable(counterValue))
    else $error("Counter moved while stopped.");
  a_write_wins: assert property (
    counterWrite |=> counterValue == $past(counterWriteData))
    else $error("Counter write was not applied.");
  a_normal_count: assert property (
    s_run(2'h0) |=> counterValue == $past(counterValue) + 8'h01)
    else $error("Normal mode did not count up by one.");
  a_overflow_set: assert property (
    s_run(2'h0) ##0 counterValue == 8'hff |=> overflowFlag)
    else $error("Overflow flag missed at wrap.");
  a_match_flag: assert property (
    s_run(2'h0) ##0 counterValue == compareValue |-> ##[1:3] compareFlag)
    else $error("Compare flag missed after match.");
  a_irq_gate: assert property (
    compareIrq == (compareFlag && compareIrqEnable && globalIrqEnable) &&
    overflowIrq == (overflowFlag && overflowIrqEnable && globalIrqEnable))
    else $error("Request does not follow flag and enables.");
  a_stop_clear: assert property (
    s_stopped ##0 (clearCompareFlag || compareIrqAck) |=> !compareFlag)
    else $error("Compare flag not cleared.");
  a_force_action: assert property (
    s_stopped ##0 forceCompare && !waveformMode[0] && !compareFlag &&
    !counterWrite |=> !compareFlag && $stable(counterValue) &&
    compareOutput == ($past(outputAction) == 2'h3 ||
    ($past(outputAction) == 2'h1 && !$past(compareOutput)) ||
    ($past(outputAction) == 2'h0 && $past(compareOutput))))
    else $error("Forced compare gave a wrong result.");
  a_ctc_clear: assert property (
    s_run(2'h2) ##0 counterValue == compareValue |->
    ##[1:2] counterValue == 8'h00)
    else $error("Clear-on-match did not clear the counter.");
  a_fast_wrap: assert property (
    s_run(2'h3) ##0 counterValue == 8'hff |=> counterValue == 8'h00)
    else $error("Fast PWM did not restart from bottom.");
  a_phase_turn: assert property (
    s_run(2'h1) ##0 counterValue == 8'hff |=> counterValue == 8'hfe)
    else $error("Phase PWM did not turn down at max.");
  a_reset_clear: assert property (disable iff (1'b0)
    reset |=> !compareOutput && !compareFlag && counterValue == 8'h00)
    else $error("Reset left state set.");
endmodule // tmr8_timer_sva
bind tmr8_timer tmr8_timer_sva #(.CountWidth(CountWidth)) i_sva (.clk,
  .reset, .clockSelect, .waveformMode, .outputAction, .forceCompare,
  .compareIrqEnable, .overflowIrqEnable, .globalIrqEnable, .counterWrite,
  .counterWriteData, .compareWrite, .clearCompareFlag, .compareIrqAck,
  .counterValue, .compareValue, .compareFlag, .overflowFlag, .compareIrq,
  .overflowIrq, .compareOutput);

// ### bench/tmr8_cpu_model.sv
// Processor stand-in that executes timer interrupts after a delay.
`timescale 1ns/100ps
module tmr8_cpu_model #(
  parameter int AckDelay = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Requests from the timer.
  input wire logic compareIrq,
  input wire logic overflowIrq,
  // Interrupt execution strobes.
  output logic compareIrqAck,
  output logic overflowIrqAck
);
  // Cycles a request has waited; a slow core leaves it standing a while.
  int wait_q;
  // Executes one vector at a time, compare first, as one-cycle strobes.
  always_ff @(posedge clk) begin
    compareIrqAck <= 1'b0;
    overflowIrqAck <= 1'b0;
    if (reset || !(compareIrq || overflowIrq)) begin
      wait_q <= 0;
    end else if (wait_q < AckDelay) begin
      wait_q <= wait_q + 1;
    end else begin
      compareIrqAck <= compareIrq;
      overflowIrqAck <= !compareIrq && overflowIrq;
      wait_q <= 0;
    end
  end
endmodule // tmr8_cpu_model

// ### bench/tmr8_timer_bench.sv
// Self-checking testbench for the eight-bit timer.
`timescale 1ns/100ps
module tmr8_timer_bench;
  // Stimulus, all defined from time zero.
  logic clk = 1'b0, reset = 1'b1, forceCompare = 1'b0, extCountPin = 1'b0;
  logic [2:0] clockSelect = 3'h0;
  logic [1:0] waveformMode = 2'h0, outputAction = 2'h0;
  logic compareIrqEnable = 1'b1, overflowIrqEnable = 1'b1;
  logic globalIrqEnable = 1'b0, counterWrite = 1'b0, compareWrite = 1'b0;
  logic clearCompareFlag = 1'b0, clearOverflowFlag = 1'b0;
  logic [7:0] counterWriteData = 8'h00, compareWriteData = 8'h00;
  // Outputs and partner strobes.
  logic [7:0] counterValue, compareValue;
  logic compareFlag, overflowFlag, compareIrq, overflowIrq, compareOutput;
  logic compareIrqAck, overflowIrqAck;
  int errors = 0, nTests = 0;
  tmr8_timer i_dut (.clk, .reset, .clockSelect, .waveformMode,
    .outputAction, .forceCompare, .compareIrqEnable, .overflowIrqEnable,
    .globalIrqEnable, .counterWrite, .counterWriteData, .counterValue,
    .compareWrite, .compareWriteData, .compareValue, .clearCompareFlag,
    .clearOverflowFlag, .compareIrqAck, .overflowIrqAck, .extCountPin,
    .compareFlag, .overflowFlag, .compareIrq, .overflowIrq, .compareOutput);
  tmr8_cpu_model #(.AckDelay(2)) i_cpu (.clk, .reset, .compareIrq,
    .overflowIrq, .compareIrqAck, .overflowIrqAck);
  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end
  // Inputs move on falling edges, away from the sampling edge.
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic wrCnt(logic [7:0] v);
    counterWriteData = v;
    pulse(counterWrite);
  endtask
  task automatic wrCmp(logic [7:0] v);
    compareWriteData = v;
    pulse(compareWrite);
  endtask
  // Bounded waits, so a dead counter reports instead of hanging.
  task automatic waitCnt(logic [7:0] v);
    int n;
    n = 0;
    while (counterValue !== v && n < 600) begin
      step(1);
      n++;
    end
    check("counter reached", v, counterValue);
  endtask
  task automatic waitFlag;
    int n;
    n = 0;
    while (compareFlag !== 1'b1 && n < 600) begin
      step(1);
      n++;
    end
    check("compare flag", 8'h01, 8'(compareFlag));
  endtask
  // Cycles between two counter changes, the first change being arbitrary.
  task automatic period(output int n);
    logic [7:0] v;
    repeat (2) begin
      v = counterValue;
      n = 0;
      while (counterValue === v && n < 3000) begin
        step(1);
        n++;
      end
    end
  endtask
  task automatic extPulse;
    extCountPin = 1'b1;
    step(4);
    extCountPin = 1'b0;
    step(4);
  endtask
  task automatic finish_test;
    $display("Checks %0d, errors %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run is near 3150 cycles; this limit is a generous margin.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  // Main sequence.
  initial begin
    logic [1:0] acts [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
    logic [4:0] outs = 5'h05;
    int divs [5] = '{1, 8, 64, 256, 1024};
    logic [7:0] mx;
    int n;
    step(2);
    reset = 1'b0;
    check("output after reset", 8'h00, 8'(compareOutput));
    wrCnt(8'h5a);
    check("stopped write", 8'h5a, counterValue);
    step(5);
    check("stopped hold", 8'h5a, counterValue);
    clockSelect = 3'h1;
    step(2);
    wrCnt(8'hfe);
    check("write beats count", 8'hfe, counterValue);
    step(1);
    check("count up", 8'hff, counterValue);
    step(1);
    check("wrap", 8'h00, counterValue);
    check("overflow flag", 8'h01, 8'(overflowFlag));
    check("overflow masked", 8'h00, 8'(overflowIrq));
    pulse(clearOverflowFlag);
    check("overflow clear", 8'h00, 8'(overflowFlag));
    clockSelect = 3'h0;
    step(3);
    pulse(clearCompareFlag);
    check("flag clear", 8'h00, 8'(compareFlag));
    wrCmp(8'h40);
    check("compare direct", 8'h40, compareValue);
    wrCnt(8'h40);
    clockSelect = 3'h1;
    step(3);
    check("blocked match", 8'h00, 8'(compareFlag));
    waitFlag();
    check("irq no global", 8'h00, 8'(compareIrq));
    globalIrqEnable = 1'b1;
    #1;
    check("irq raised", 8'h01, 8'(compareIrq));
    step(6);
    check("flag after ack", 8'h00, 8'(compareFlag));
    // Output set up while stopped, before any pin would be enabled.
    clockSelect = 3'h0;
    step(3);
    for (int i = 0; i < 5; i++) begin
      outputAction = acts[i];
      pulse(forceCompare);
      check("forced output", 8'(outs[i]), 8'(compareOutput));
      check("forced no flag", 8'h00, 8'(compareFlag));
    end
    outputAction = 2'h3;
    pulse(forceCompare);
    waveformMode = 2'h3;
    step(2);
    waveformMode = 2'h0;
    step(1);
    check("output kept", 8'h01, 8'(compareOutput));
    waveformMode = 2'h2;
    outputAction = 2'h0;
    wrCmp(8'h05);
    wrCnt(8'h00);
    clockSelect = 3'h1;
    mx = 8'h00;
    repeat (20) begin
      step(1);
      if (counterValue > mx) begin
        mx = counterValue;
      end
    end
    check("match top", 8'h05, mx);
    // Inverted fast PWM: a late write must wait for the next max.
    outputAction = 2'h3;
    waveformMode = 2'h3;
    wrCmp(8'h80);
    waitCnt(8'hff);
    waitCnt(8'h40);
    wrCmp(8'h10);
    check("buffer read", 8'h10, compareValue);
    waitCnt(8'hc0);
    check("old compare", 8'h01, 8'(compareOutput));
    waitCnt(8'hff);
    step(1);
    check("fast restart", 8'h00, counterValue);
    waitCnt(8'h08);
    check("bottom clear", 8'h00, 8'(compareOutput));
    waitCnt(8'h20);
    check("match set", 8'h01, 8'(compareOutput));
    waveformMode = 2'h1;
    waitCnt(8'hff);
    step(1);
    check("down slope", 8'hfe, counterValue);
    waitCnt(8'h08);
    check("phase down match", 8'h00, 8'(compareOutput));
    waveformMode = 2'h0;
    for (int i = 0; i < 5; i++) begin
      clockSelect = 3'(i + 1);
      period(n);
      check("tick period", 8'h00, 8'(n != divs[i]));
    end
    for (int e = 0; e < 2; e++) begin
      clockSelect = 3'(6 + e);
      wrCnt(8'h00);
      repeat (4) extPulse();
      step(6);
      check("pin edges", 8'h04, counterValue);
    end
    finish_test();
  end
endmodule // tmr8_timer_bench
